// File: inc/rtcs_pkg.sv
package rtcs_pkg;

  // Bus and data widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int NBYTES = 4;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SNAP0 = 6'h00;
  localparam logic [5:0] IDX_SNAP1 = 6'h01;
  localparam logic [5:0] IDX_SNAP2 = 6'h02;
  localparam logic [5:0] IDX_SNAP3 = 6'h03;
  localparam logic [5:0] IDX_CTRL  = 6'h04;
  localparam logic [5:0] IDX_STAT  = 6'h05;
  localparam logic [5:0] IDX_MASK  = 6'h06;
  localparam logic [5:0] IDX_WAKE0 = 6'h08;
  localparam logic [5:0] IDX_WAKE1 = 6'h09;
  localparam logic [5:0] IDX_WAKE2 = 6'h0a;
  localparam logic [5:0] IDX_WAKE3 = 6'h0b;

  // Control register fields
  localparam int CTL_LOAD_BIT = 0;
  localparam int CTL_SNAP_BIT = 1;
  localparam int CTL_AEN_BIT  = 2;
  localparam int CTL_RUN_BIT  = 3;

  // Status and mask register fields
  localparam int STAT_ALARM_BIT = 0;
  localparam int STAT_WRAP_BIT  = 1;
  localparam int NEVENTS        = 2;

  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [3:0]  RST_CTRL  = 4'h0;
  localparam logic [1:0]  RST_EVT   = 2'h0;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;

endpackage

// File: verilog/rtcs_sync.sv
`timescale 1ns/100ps
`default_nettype none

module rtcs_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      rise_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // Three-stage synchroniser; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered level follows only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
      rise_q <= (s2_q == s3_q) && s3_q && !level_q;
    end
  end

endmodule

`default_nettype wire

// File: verilog/rtcs_timer.sv
`timescale 1ns/100ps
`default_nettype none

module rtcs_timer
  import rtcs_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              tick,
  input  wire logic              run,
  input  wire logic              load,
  input  wire logic [DATA_W-1:0] load_value,
  input  wire logic [DATA_W-1:0] alarm_value,
  input  wire logic              alarm_en,
  output logic      [DATA_W-1:0] count_q,
  output logic                   alarm_hit_q,
  output logic                   wrap_q
);

  logic [DATA_W-1:0] next_count;

  assign next_count = count_q + 32'h0000_0001;

  // Free-running count; a load wins over a tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= RST_WORD;
    end else if (load) begin
      count_q <= load_value;
    end else if (run && tick) begin
      count_q <= next_count;
    end
  end

  // Alarm fires when the count steps onto the programmed value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_hit_q <= 1'b0;
      wrap_q      <= 1'b0;
    end else begin
      alarm_hit_q <= !load && run && tick && alarm_en && (next_count == alarm_value);
      wrap_q      <= !load && run && tick && (count_q == 32'hffff_ffff);
    end
  end

endmodule

`default_nettype wire

// File: verilog/rtcs_top.sv
// Summary of operation
// - Four snapshot bytes together read or load the full 32-bit timer.
// - Timer and snapshot bytes exchange data only on load or snapshot bit.
// - Four alarm bytes hold a 32-bit value that raises the alarm event.
// - Snapshot bytes two and three sit at 0x02 and 0x03, RW, reset zero.
// - Alarm bytes zero to two sit at 0x08, 0x09, 0x0A, RW, reset zero.
// - Snapshot byte one sits at 0x01, RW, reset zero.
// - Alarm byte three sits at 0x0B, RW, reset zero.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module rtcs_top (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [rtcs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [rtcs_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [rtcs_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       rtc_osc,
  output logic                            irq
);
  import rtcs_pkg::*;

  // Register storage, addressed by byte index
  logic [BYTE_W-1:0]  snap_q [NBYTES];
  logic [BYTE_W-1:0]  wake_q [NBYTES];
  logic               aen_q;
  logic               run_q;
  logic               load_pulse_q;
  logic               snap_pulse_q;
  logic [NEVENTS-1:0] stat_q;
  logic [NEVENTS-1:0] mask_q;

  // Bus response flops
  logic [DATA_W-1:0]  prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic               irq_q;

  // Bus decode
  logic [5:0]         idx;
  logic               setup_cyc;
  logic               wr_take;
  logic               wr_lane0;
  logic [BYTE_W-1:0]  wbyte;
  logic [DATA_W-1:0]  rd_word;

  // Per-register write strobes
  logic               wr_snap;
  logic               wr_wake;
  logic               wr_ctrl;
  logic               wr_stat;
  logic               wr_mask;

  // Timer interface
  logic               osc_tick;
  logic [DATA_W-1:0]  count;
  logic [DATA_W-1:0]  snap_word;
  logic [DATA_W-1:0]  wake_word;
  logic               alarm_hit;
  logic               wrap_hit;
  logic [NEVENTS-1:0] evt_set;
  logic [NEVENTS-1:0] evt_clr;

  // True when the index names a register of the map
  function automatic logic addr_hit(input logic [5:0] i);
    case (i)
      IDX_SNAP0, IDX_SNAP1, IDX_SNAP2, IDX_SNAP3: addr_hit = 1'b1;
      IDX_CTRL, IDX_STAT, IDX_MASK:               addr_hit = 1'b1;
      IDX_WAKE0, IDX_WAKE1, IDX_WAKE2, IDX_WAKE3: addr_hit = 1'b1;
      default:                                    addr_hit = 1'b0;
    endcase
  endfunction

  // Packs four bytes, byte zero lowest
  function automatic logic [DATA_W-1:0] pack4(input logic [BYTE_W-1:0] b0,
                                              input logic [BYTE_W-1:0] b1,
                                              input logic [BYTE_W-1:0] b2,
                                              input logic [BYTE_W-1:0] b3);
    pack4 = {b3, b2, b1, b0};
  endfunction

  // True for the four snapshot byte indices
  function automatic logic is_snap(input logic [5:0] i);
    is_snap = (i <= IDX_SNAP3);
  endfunction

  // True for the four alarm byte indices
  function automatic logic is_wake(input logic [5:0] i);
    is_wake = (i >= IDX_WAKE0) && (i <= IDX_WAKE3);
  endfunction

  // Widens one register byte to a bus word, upper bits zero
  function automatic logic [DATA_W-1:0] zext8(input logic [BYTE_W-1:0] b);
    zext8 = {{(DATA_W-BYTE_W){1'b0}}, b};
  endfunction

  assign idx       = paddr[7:2];
  assign setup_cyc = psel && !penable;
  assign wr_take   = psel && penable && pready_q && pwrite && addr_hit(idx);
  assign wr_lane0  = wr_take && pstrb[0];
  assign wbyte     = pwdata[BYTE_W-1:0];

  // Accepted low-lane writes sorted by target register
  assign wr_snap   = wr_lane0 && is_snap(idx);
  assign wr_wake   = wr_lane0 && is_wake(idx);
  assign wr_ctrl   = wr_lane0 && (idx == IDX_CTRL);
  assign wr_stat   = wr_lane0 && (idx == IDX_STAT);
  assign wr_mask   = wr_lane0 && (idx == IDX_MASK);

  // Whole-word views of the byte registers
  assign snap_word = pack4(snap_q[0], snap_q[1], snap_q[2], snap_q[3]);
  assign wake_word = pack4(wake_q[0], wake_q[1], wake_q[2], wake_q[3]);

  // Slow oscillator enters the bus clock domain here
  rtcs_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (rtc_osc),
    .rise_q   (osc_tick)
  );

  // Timer counter and alarm compare
  rtcs_timer u_timer (
    .pclk        (pclk),
    .presetn     (presetn),
    .tick        (osc_tick),
    .run         (run_q),
    .load        (load_pulse_q),
    .load_value  (snap_word),
    .alarm_value (wake_word),
    .alarm_en    (aen_q),
    .count_q     (count),
    .alarm_hit_q (alarm_hit),
    .wrap_q      (wrap_hit)
  );

  // Bus answer: ready rises for the access phase after each setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_cyc;
      pslverr_q <= setup_cyc && !addr_hit(idx);
    end
  end

  // Read multiplexer over the register map
  always_comb begin
    rd_word = RST_WORD;
    case (idx)
      IDX_SNAP0: rd_word = zext8(snap_q[0]);
      IDX_SNAP1: rd_word = zext8(snap_q[1]);
      IDX_SNAP2: rd_word = zext8(snap_q[2]);
      IDX_SNAP3: rd_word = zext8(snap_q[3]);
      IDX_CTRL:  rd_word = {28'h000_0000, run_q, aen_q, 2'b00};
      IDX_STAT:  rd_word = {30'h0000_0000, stat_q};
      IDX_MASK:  rd_word = {30'h0000_0000, mask_q};
      IDX_WAKE0: rd_word = zext8(wake_q[0]);
      IDX_WAKE1: rd_word = zext8(wake_q[1]);
      IDX_WAKE2: rd_word = zext8(wake_q[2]);
      IDX_WAKE3: rd_word = zext8(wake_q[3]);
      default:   rd_word = RST_WORD;
    endcase
  end

  // Read data sampled in the setup cycle; writes and unmapped reads give zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= RST_WORD;
    end else if (setup_cyc && !pwrite) begin
      prdata_q <= rd_word;
    end else if (setup_cyc) begin
      prdata_q <= RST_WORD;
    end
  end

  // Snapshot bytes: bus writes, or capture of the running count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NBYTES; i++) begin
        snap_q[i] <= RST_BYTE;
      end
    end else if (snap_pulse_q) begin
      for (int i = 0; i < NBYTES; i++) begin
        snap_q[i] <= count[i*BYTE_W +: BYTE_W];
      end
    end else if (wr_snap) begin
      snap_q[idx[1:0]] <= wbyte;
    end
  end

  // Alarm bytes, written only by the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NBYTES; i++) begin
        wake_q[i] <= RST_BYTE;
      end
    end else if (wr_wake) begin
      wake_q[idx[1:0]] <= wbyte;
    end
  end

  // Control: enables held, load and snapshot self-clearing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aen_q        <= RST_CTRL[CTL_AEN_BIT];
      run_q        <= RST_CTRL[CTL_RUN_BIT];
      load_pulse_q <= RST_CTRL[CTL_LOAD_BIT];
      snap_pulse_q <= RST_CTRL[CTL_SNAP_BIT];
    end else begin
      load_pulse_q <= wr_ctrl && wbyte[CTL_LOAD_BIT];
      snap_pulse_q <= wr_ctrl && wbyte[CTL_SNAP_BIT];
      if (wr_ctrl) begin
        aen_q <= wbyte[CTL_AEN_BIT];
        run_q <= wbyte[CTL_RUN_BIT];
      end
    end
  end

  // Event sources and write-one-to-clear requests
  assign evt_set[STAT_ALARM_BIT] = alarm_hit;
  assign evt_set[STAT_WRAP_BIT]  = wrap_hit;
  assign evt_clr = wr_stat ? wbyte[NEVENTS-1:0] : RST_EVT;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= RST_EVT;
    end else begin
      stat_q <= (stat_q & ~evt_clr) | evt_set;
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= RST_EVT;
    end else if (wr_mask) begin
      mask_q <= wbyte[NEVENTS-1:0];
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((stat_q & ~evt_clr) | evt_set) & mask_q);
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

endmodule

`default_nettype wire

// File: test/rtcs_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module rtcs_top_monitor
  import rtcs_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr
);
  logic [5:0] idx;
  logic       unm;
  logic       setup;
  logic [7:0] wk_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Decode of the presented request
  assign idx   = paddr[7:2];
  assign unm   = (idx == 6'h07) || (idx > IDX_WAKE3);
  assign setup = psel && !penable;

  // Shadow of alarm byte zero from accepted writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_q <= RST_BYTE;
    end else if (psel && penable && pready && pwrite && pstrb[0] && idx == IDX_WAKE0) begin
      wk_q <= pwdata[7:0];
    end
  end

  AST_READY_AFTER_SETUP:
    assert property (setup |=> pready) else $error("pready missing after setup");
  AST_NO_SPURIOUS_READY:
    assert property (pready |-> $past(setup)) else $error("pready without setup");
  AST_ERR_QUAL:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_ERR_UNMAPPED:
    assert property (setup && unm |=> pslverr) else $error("unmapped access not refused");
  AST_OK_MAPPED:
    assert property (setup && !unm |=> !pslverr) else $error("mapped access refused");
  AST_RD_UNMAPPED:
    assert property (setup && unm && !pwrite |=> prdata == '0) else $error("unmapped read not zero");
  AST_UPPER_ZERO:
    assert property (setup && !pwrite |=> prdata[31:8] == '0) else $error("upper read bits set");
  AST_WAKE0_RD:
    assert property (setup && !pwrite && idx == IDX_WAKE0 |=> prdata[7:0] == $past(wk_q))
      else $error("alarm byte zero readback wrong");
endmodule

bind rtcs_top rtcs_top_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));

`default_nettype wire

// File: test/rtcs_top_bench.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end

module rtcs_top_bench;
  import rtcs_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rtc_osc = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  pstrb = 0;
  logic        pready, pslverr, irq, er;
  int          err_count = 0, n_checks = 0, cyc = 0;

  // Clock and design
  always #5 pclk = ~pclk;
  rtcs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rtc_osc(rtc_osc), .irq(irq));

  // One APB transfer, held until pready
  task automatic xfer(input logic [5:0] i, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'hff_ffff, d};
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    xfer(i, 1'b1, d);
  endtask

  task automatic rdc(input logic [5:0] i, input logic [7:0] e, input string n);
    xfer(i, 1'b0, 8'h00);
    `CHK(n, {24'h00_0000, e}, rd)
  endtask

  // Four bytes, lowest index as least significant
  task automatic wr4(input logic [5:0] b, input logic [31:0] v);
    for (int k = 0; k < 4; k++) wr(6'(b + k), v[8*k +: 8]);
  endtask

  task automatic rd4(input logic [5:0] b, input logic [31:0] v);
    for (int k = 0; k < 4; k++) rdc(6'(b + k), v[8*k +: 8], "byte of word");
  endtask

  // One slow oscillator period
  task automatic tick();
    rtc_osc <= 1;
    repeat (5) @(posedge pclk);
    rtc_osc <= 0;
    repeat (5) @(posedge pclk);
  endtask

  task automatic t_reset();
    rd4(IDX_SNAP0, 32'h0000_0000);
    rd4(IDX_WAKE0, 32'h0000_0000);
  endtask

  task automatic t_rw();
    wr4(IDX_SNAP0, 32'h5ac3_96e1);
    wr4(IDX_WAKE0, 32'h1e69_3ca5);
    rd4(IDX_SNAP0, 32'h5ac3_96e1);
    rd4(IDX_WAKE0, 32'h1e69_3ca5);
  endtask

  task automatic t_unm();
    wr(6'h07, 8'h55);
    `CHK("unmapped write err", 1'b1, er)
    rdc(6'h07, 8'h00, "unmapped read");
    `CHK("unmapped read err", 1'b1, er)
    rdc(6'h0c, 8'h00, "beyond map read");
  endtask

  task automatic t_load();
    wr4(IDX_SNAP0, 32'h1122_3344);
    wr(IDX_CTRL, 8'h01);
    wr4(IDX_SNAP0, 32'h0000_0000);
    rdc(IDX_SNAP0, 8'h00, "no transfer without bit");
    wr(IDX_CTRL, 8'h02);
    rd4(IDX_SNAP0, 32'h1122_3344);
  endtask

  task automatic t_alarm();
    wr(IDX_CTRL, 8'h00);
    wr4(IDX_WAKE0, 32'h0000_0101);
    wr4(IDX_SNAP0, 32'h0000_00ff);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_MASK, 8'h01);
    wr(IDX_CTRL, 8'h0c);
    tick();
    rdc(IDX_STAT, 8'h00, "status before match");
    tick();
    repeat (8) @(posedge pclk);
    rdc(IDX_STAT, 8'h01, "alarm status");
    `CHK("irq on alarm", 1'b1, irq)
    wr(IDX_CTRL, 8'h0e);
    rd4(IDX_SNAP0, 32'h0000_0101);
    wr(IDX_STAT, 8'h01);
    rdc(IDX_STAT, 8'h00, "status cleared");
    `CHK("irq cleared", 1'b0, irq)
    wr(IDX_CTRL, 8'h00);
    wr4(IDX_SNAP0, 32'hffff_fffe);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_CTRL, 8'h08);
    tick();
    tick();
    repeat (8) @(posedge pclk);
    rdc(IDX_STAT, 8'h02, "wrap status");
    `CHK("irq masked", 1'b0, irq)
    wr(IDX_MASK, 8'h02);
    repeat (3) @(posedge pclk);
    `CHK("irq unmasked", 1'b1, irq)
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_rw();
    t_unm();
    t_load();
    t_alarm();
    close_out();
  end
endmodule

`default_nettype wire
